// File: hdl/rjb_exec.sv
/*
 * Execution block for return jumps, repeat, index skip, index jump and
 * buffer initiation, plus the per-word buffer transfer sequencer.
 * Assumes a single-port storage that holds mem_req_o until a one-cycle
 * mem_ack_i, with read data valid alongside the ack, and a core that
 * issues one instruction at a time while ready_o is high.
 */
`timescale 1ns/1ps
module rjb_exec
   import rjb_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire logic [5:0] opcode_i,
   input wire logic [2:0] branch_sel_i,
   input wire logic [2:0] transfer_i,
   input wire logic [WORD_W-1:0] operand_i,
   input wire logic [WORD_W-1:0] acc_i,
   input wire logic [WORD_W-1:0] q_i,
   input wire logic [7:1] key_i,
   input wire logic [7:1] chan_full_i,
   input wire logic [7:1] xfer_req_i,
   input wire logic [WORD_W-1:0] chan_data_i,
   input wire logic pass_i,
   input wire logic branch_met_i,
   input wire logic run_i,
   input wire logic pc_load_i,
   input wire logic [HALF_W-1:0] pc_load_val_i,
   input wire logic mem_ack_i,
   input wire logic [WORD_W-1:0] mem_rdata_i,
   output logic ready_o,
   output logic done_o,
   output logic [HALF_W-1:0] pc_o,
   output logic halt_o,
   output logic repeat_active_o,
   output logic [1:0] repeat_mode_o,
   output logic [HALF_W-1:0] repeat_count_o,
   output logic [7:1] buf_in_active_o,
   output logic [7:1] buf_out_active_o,
   output logic [7:1] xfer_ack_o,
   output logic [2:0] chan_sel_o,
   output logic chan_wr_o,
   output logic [WORD_W-1:0] chan_data_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic mem_lo_en_o,
   output logic mem_hi_en_o,
   output logic [HALF_W-1:0] mem_addr_o,
   output logic [WORD_W-1:0] mem_wdata_o
);
   typedef struct packed {
      seq_state_e st;
      logic [HALF_W-1:0] pc;
      logic [7:1][HALF_W-1:0] idx;
      logic [HALF_W-1:0] xreg;
      logic stop_pend;
      logic halt;
      logic rep_act;
      logic [1:0] rep_mode;
      logic [7:1] buf_in;
      logic [7:1] buf_out;
      logic [7:1] pend;
      logic [7:1] req_prev;
      logic [7:1] xack;
      logic [2:0] ch;
      logic [HALF_W-1:0] baddr;
      logic [HALF_W-1:0] bterm;
      logic done;
      logic cwr;
      logic [WORD_W-1:0] cdata;
      logic mreq;
      logic mwe;
      logic mlo;
      logic mhi;
      logic [HALF_W-1:0] maddr;
      logic [WORD_W-1:0] mwdata;
   } exec_s;

   exec_s q;
   exec_s d;

   logic [7:1] key_s;
   logic [7:1] req_s;
   logic take;
   logic stop;
   logic [7:1] svc;
   logic [2:0] svc_ch;
   logic [HALF_W-1:0] y_lo;
   logic [HALF_W-1:0] sel_idx;
   rjb_sync2 #(.WIDTH(14)) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .async_i({key_i, xfer_req_i}),
      .sync_o({key_s, req_s})
   );
   rjb_cond u_cond (
      .opcode_i(opcode_i),
      .sel_i(branch_sel_i),
      .acc_i(acc_i),
      .q_i(q_i),
      .key_i(key_s),
      .chan_full_i(chan_full_i),
      .take_o(take),
      .stop_o(stop)
   );
   // Index 0 names no register and always reads as zero.
   function automatic logic [HALF_W-1:0] idx_read(
      input logic [7:1][HALF_W-1:0] regs,
      input logic [2:0] sel
   );
      idx_read = (sel == 3'h0) ? '0 : regs[sel];
   endfunction
   // Lowest numbered channel wins when several requests are pending.
   function automatic logic [2:0] lowest_chan(input logic [7:1] v);
      lowest_chan = 3'h0;
      for (int i = 7; i >= 1; i--) begin
         if (v[i]) lowest_chan = 3'(i);
      end
   endfunction
   assign y_lo = operand_i[LO_LSB +: HALF_W];
   assign sel_idx = idx_read(q.idx, branch_sel_i);
   assign svc = q.pend & (q.buf_in | q.buf_out);
   assign svc_ch = lowest_chan(svc);

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.cwr = 1'b0;
      d.xack = '0;
      d.req_prev = req_s;
      if (run_i) d.halt = 1'b0;
      if (pc_load_i) d.pc = pc_load_val_i;
      if (q.rep_act && pass_i) begin
         d.idx[REPEAT_COUNT_REG] = q.idx[REPEAT_COUNT_REG] - 15'h0001;
         if ((q.idx[REPEAT_COUNT_REG] == 15'h0001) || branch_met_i) begin
            d.rep_act = 1'b0;
         end
      end
      unique case (q.st)
         ST_IDLE: begin
            // Buffer words take priority and hold off the next instruction.
            if (svc != '0) begin
               d.ch = svc_ch;
               d.pend[svc_ch] = 1'b0;
               d.mreq = 1'b1;
               d.mwe = 1'b0;
               d.maddr = {12'h000, svc_ch};
               d.st = ST_BUF_READ_CTL;
            end else if (start_i) begin
               unique case (opcode_i)
                  OP_ARITH_RJ, OP_MANUAL_RJ, OP_INPUT_RJ, OP_OUTPUT_RJ: begin
                     if (take) begin
                        d.xreg = q.pc;
                        d.pc = y_lo;
                        d.stop_pend = stop;
                        d.mreq = 1'b1;
                        d.mwe = 1'b1;
                        d.mlo = 1'b1;
                        d.mhi = 1'b0;
                        d.maddr = y_lo;
                        d.mwdata = {15'h0000, q.pc};
                        d.st = ST_RJ_WRITE;
                     end else begin
                        d.done = 1'b1;
                     end
                  end
                  OP_REPEAT: begin
                     d.idx[REPEAT_COUNT_REG] = y_lo;
                     d.rep_act = (y_lo != '0);
                     d.rep_mode = branch_sel_i[1:0];
                     d.done = 1'b1;
                  end
                  OP_INDEX_SKIP: begin
                     if (sel_idx == y_lo) begin
                        d.pc = q.pc + 15'h0001;
                        if (branch_sel_i != 3'h0) begin
                           d.idx[branch_sel_i] = '0;
                        end
                     end else if (branch_sel_i != 3'h0) begin
                        d.idx[branch_sel_i] = sel_idx + 15'h0001;
                     end
                     d.done = 1'b1;
                  end
                  OP_INDEX_JUMP: begin
                     if (sel_idx != '0) begin
                        d.pc = y_lo;
                        d.idx[branch_sel_i] = sel_idx - 15'h0001;
                     end
                     d.done = 1'b1;
                  end
                  OP_INIT_IN_BUF, OP_INIT_OUT_BUF: begin
                     if (branch_sel_i == 3'h0) begin
                        d.done = 1'b1;
                     end else begin
                        d.mreq = 1'b1;
                        d.mwe = 1'b1;
                        d.mlo = 1'b1;
                        d.mhi = (transfer_i == K_FULL_WORD);
                        d.maddr = {12'h000, branch_sel_i};
                        d.mwdata = operand_i;
                        d.pend[branch_sel_i] = 1'b0;
                        d.buf_in[branch_sel_i] = (opcode_i == OP_INIT_IN_BUF);
                        d.buf_out[branch_sel_i] = (opcode_i == OP_INIT_OUT_BUF);
                        d.st = ST_BINIT_WRITE;
                     end
                  end
                  default: d.done = 1'b1;
               endcase
            end
         end
         ST_RJ_WRITE: begin
            if (mem_ack_i) begin
               d.mreq = 1'b0;
               d.pc = q.pc + 15'h0001;
               d.halt = q.halt | q.stop_pend;
               d.stop_pend = 1'b0;
               d.done = 1'b1;
               d.st = ST_IDLE;
            end
         end
         ST_BINIT_WRITE: begin
            if (mem_ack_i) begin
               d.mreq = 1'b0;
               d.done = 1'b1;
               d.st = ST_IDLE;
            end
         end
         ST_BUF_READ_CTL: begin
            if (mem_ack_i) begin
               d.baddr = mem_rdata_i[LO_LSB +: HALF_W];
               d.bterm = mem_rdata_i[HI_LSB +: HALF_W];
               d.maddr = mem_rdata_i[LO_LSB +: HALF_W];
               d.mwe = q.buf_in[q.ch];
               d.mlo = 1'b1;
               d.mhi = 1'b1;
               d.mwdata = chan_data_i;
               d.st = ST_BUF_XFER;
            end
         end
         ST_BUF_XFER: begin
            if (mem_ack_i) begin
               if (!q.mwe) begin
                  d.cdata = mem_rdata_i;
                  d.cwr = 1'b1;
               end
               d.mwe = 1'b1;
               d.mhi = 1'b0;
               d.maddr = {12'h000, q.ch};
               d.mwdata = {15'h0000, q.baddr + 15'h0001};
               d.st = ST_BUF_WRITE_CTL;
            end
         end
         ST_BUF_WRITE_CTL: begin
            if (mem_ack_i) begin
               d.mreq = 1'b0;
               d.xack[q.ch] = 1'b1;
               if (q.baddr + 15'h0001 == q.bterm) begin
                  d.buf_in[q.ch] = 1'b0;
                  d.buf_out[q.ch] = 1'b0;
               end
               d.st = ST_IDLE;
            end
         end
      endcase
      // one word per request edge; a new edge beats a clear
      d.pend = d.pend | (req_s & ~q.req_prev & (d.buf_in | d.buf_out));
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         q <= '{st: ST_IDLE, pc: PC_RESET, default: '0};
      end else begin
         q <= d;
      end
   end
   assign ready_o = (q.st == ST_IDLE) && (svc == '0);
   assign done_o = q.done;
   assign pc_o = q.pc;
   assign halt_o = q.halt;
   assign repeat_active_o = q.rep_act;
   assign repeat_mode_o = q.rep_mode;
   assign repeat_count_o = q.idx[REPEAT_COUNT_REG];
   assign buf_in_active_o = q.buf_in;
   assign buf_out_active_o = q.buf_out;
   assign xfer_ack_o = q.xack;
   assign chan_sel_o = q.ch;
   assign chan_wr_o = q.cwr;
   assign chan_data_o = q.cdata;
   assign mem_req_o = q.mreq;
   assign mem_we_o = q.mwe;
   assign mem_lo_en_o = q.mlo;
   assign mem_hi_en_o = q.mhi;
   assign mem_addr_o = q.maddr;
   assign mem_wdata_o = q.mwdata;
endmodule

// File: hdl/rjb_pkg.sv
/*
 * Shared constants for the return jump, repeat, index and buffer
 * initiation execution block: word layout, opcodes, field codes and
 * the sequencer state type.
 * Assumes 30-bit storage words split into two 15-bit halves.
 */
package rjb_pkg;

   localparam int WORD_W = 30;
   localparam int HALF_W = 15;
   localparam int NCHAN = 7;
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 15;

   // Opcodes, six bits, octal 64..76.
   localparam logic [5:0] OP_ARITH_RJ = 6'h34;
   localparam logic [5:0] OP_MANUAL_RJ = 6'h35;
   localparam logic [5:0] OP_INPUT_RJ = 6'h36;
   localparam logic [5:0] OP_OUTPUT_RJ = 6'h37;
   localparam logic [5:0] OP_REPEAT = 6'h38;
   localparam logic [5:0] OP_INDEX_SKIP = 6'h39;
   localparam logic [5:0] OP_INDEX_JUMP = 6'h3A;
   localparam logic [5:0] OP_INIT_IN_BUF = 6'h3D;
   localparam logic [5:0] OP_INIT_OUT_BUF = 6'h3E;

   localparam logic [2:0] K_FULL_WORD = 3'h3;
   localparam logic [2:0] J_STOP_ALWAYS = 3'h4;
   localparam logic [2:0] REPEAT_COUNT_REG = 3'h7;

   // Repeat modification modes, low two bits of the branch select field.
   localparam logic [1:0] RMOD_NONE = 2'h0;
   localparam logic [1:0] RMOD_INC = 2'h1;
   localparam logic [1:0] RMOD_DEC = 2'h2;
   localparam logic [1:0] RMOD_REINDEX = 2'h3;

   localparam logic [14:0] PC_RESET = 15'h0000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RJ_WRITE,
      ST_BINIT_WRITE,
      ST_BUF_READ_CTL,
      ST_BUF_XFER,
      ST_BUF_WRITE_CTL
   } seq_state_e;

endpackage

// File: hdl/rjb_sync2.sv
/*
 * Two flip-flop level synchroniser for a bundle of pin inputs.
 * Assumes each bit is an independent level; no bundle coherency.
 */
`timescale 1ns/1ps
module rjb_sync2 #(
   parameter int WIDTH = 14
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_s;

   sync_s q;
   sync_s d;

   always_comb begin
      d.stage1 = async_i;
      d.stage2 = q.stage1;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.stage2;
endmodule

// File: hdl/rjb_cond.sv
/*
 * Combinational condition evaluator for the four return jump opcodes.
 * Assumes accumulator and Q are ones' complement words, and that keys
 * are already synchronised. Has no state.
 */
`timescale 1ns/1ps
module rjb_cond
   import rjb_pkg::*;
(
   input wire logic [5:0] opcode_i,
   input wire logic [2:0] sel_i,
   input wire logic [WORD_W-1:0] acc_i,
   input wire logic [WORD_W-1:0] q_i,
   input wire logic [7:1] key_i,
   input wire logic [7:1] chan_full_i,
   output logic take_o,
   output logic stop_o
);
   logic acc_zero;
   logic sel_key;
   logic sel_full;

   // Both ones' complement zeros count as zero.
   assign acc_zero = (acc_i == '0) || (acc_i == '1);
   assign sel_key = (sel_i == 3'h0) ? 1'b0 : key_i[sel_i];
   assign sel_full = (sel_i == 3'h0) ? 1'b0 : chan_full_i[sel_i];

   always_comb begin
      take_o = 1'b0;
      stop_o = 1'b0;
      unique case (opcode_i)
         OP_ARITH_RJ: begin
            unique case (sel_i)
               3'h0: take_o = 1'b0;
               3'h1: take_o = 1'b1;
               3'h2: take_o = ~q_i[WORD_W-1];
               3'h3: take_o = q_i[WORD_W-1];
               3'h4: take_o = acc_zero;
               3'h5: take_o = ~acc_zero;
               3'h6: take_o = ~acc_i[WORD_W-1];
               3'h7: take_o = acc_i[WORD_W-1];
            endcase
         end
         OP_MANUAL_RJ: begin
            take_o = sel_i[2] || (sel_i == 3'h0) || sel_key;
            stop_o = (sel_i == J_STOP_ALWAYS) || (sel_i[2] && sel_key);
         end
         OP_INPUT_RJ: take_o = sel_full;
         OP_OUTPUT_RJ: take_o = ~sel_full;
         default: begin
            take_o = 1'b0;
            stop_o = 1'b0;
         end
      endcase
   end
endmodule

// File: dv/rjb_mem_model.sv
/* Storage partner: 32 words, ack pulse, optional stall.
   Assumes the request is held until the ack. */
`timescale 1ns/1ps
module rjb_mem_model
   import rjb_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic slow_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic lo_i,
   input wire logic hi_i,
   input wire logic [HALF_W-1:0] addr_i,
   input wire logic [WORD_W-1:0] wdata_i,
   output logic ack_o,
   output logic [WORD_W-1:0] rdata_o
);
   logic [WORD_W-1:0] mem_q [0:31];
   logic [1:0] wait_q;
   // Read data toggles off the ack so a late sample never matches by luck.
   always @(posedge clock_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (sys_rst_i) begin
         wait_q <= 2'h0;
         rdata_o <= 30'h15555555;
      end else if (req_i && !ack_o) begin
         wait_q <= wait_q + 2'h1;
         if (wait_q == 2'h3 || !slow_i) begin
            wait_q <= 2'h0;
            ack_o <= 1'b1;
            rdata_o <= mem_q[addr_i[4:0]];
            if (we_i && lo_i) mem_q[addr_i[4:0]][14:0] <= wdata_i[14:0];
            if (we_i && hi_i) mem_q[addr_i[4:0]][29:15] <= wdata_i[29:15];
         end
      end
   end
endmodule

// File: dv/rjb_exec_chk.sv
/* Port checker for rjb_exec.
   Assumes the storage holds its answer for one ack cycle. */
`timescale 1ns/1ps
module rjb_exec_chk
   import rjb_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire logic ready_o,
   input wire logic [5:0] opcode_i,
   input wire logic [2:0] branch_sel_i,
   input wire logic [2:0] transfer_i,
   input wire logic [WORD_W-1:0] operand_i,
   input wire logic [7:1] chan_full_i,
   input wire logic pass_i,
   input wire logic branch_met_i,
   input wire logic done_o,
   input wire logic [HALF_W-1:0] pc_o,
   input wire logic repeat_active_o,
   input wire logic [1:0] repeat_mode_o,
   input wire logic [HALF_W-1:0] repeat_count_o,
   input wire logic [7:1] buf_in_active_o,
   input wire logic [7:1] buf_out_active_o,
   input wire logic mem_req_o,
   input wire logic mem_ack_i,
   input wire logic mem_we_o,
   input wire logic mem_lo_en_o,
   input wire logic mem_hi_en_o,
   input wire logic [HALF_W-1:0] mem_addr_o,
   input wire logic [WORD_W-1:0] mem_wdata_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic iss;
   logic [2:0] sel;
   assign iss = start_i && ready_o;
   assign sel = branch_sel_i;
   property p_req_hold;
      mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_wdata_o);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request moved before ack");
   property p_rj_write;
      iss && opcode_i == OP_MANUAL_RJ && sel == J_STOP_ALWAYS |=> mem_req_o && mem_we_o
         && mem_lo_en_o && !mem_hi_en_o && mem_addr_o == $past(operand_i[14:0])
         && pc_o == mem_addr_o && mem_wdata_o[14:0] == $past(pc_o);
   endproperty
   a_rj_write: assert property (p_rj_write) else $error("return save wrong");
   property p_rj_end;
      mem_ack_i && mem_we_o && !mem_hi_en_o && mem_addr_o > 15'h0007 && mem_addr_o == pc_o
         |=> done_o && pc_o == $past(pc_o) + 15'h0001;
   endproperty
   a_rj_end: assert property (p_rj_end) else $error("return advance wrong");
   property p_untaken;
      iss && opcode_i == OP_INPUT_RJ && sel != 3'h0 && !chan_full_i[sel]
         |=> done_o && !mem_req_o && pc_o == $past(pc_o);
   endproperty
   a_untaken: assert property (p_untaken) else $error("empty channel jumped");
   property p_binit;
      iss && (opcode_i == OP_INIT_IN_BUF || opcode_i == OP_INIT_OUT_BUF) && sel != 3'h0
         |=> mem_req_o && mem_we_o && mem_addr_o == 15'($past(sel))
         && mem_hi_en_o == ($past(transfer_i) == K_FULL_WORD)
         && mem_wdata_o[14:0] == $past(operand_i[14:0]);
   endproperty
   a_binit: assert property (p_binit) else $error("control store wrong");
   property p_bout;
      iss && opcode_i == OP_INIT_OUT_BUF && sel != 3'h0
         |=> buf_out_active_o[$past(sel)] && !buf_in_active_o[$past(sel)];
   endproperty
   a_bout: assert property (p_bout) else $error("output mode not set");
   property p_rep_load;
      iss && opcode_i == OP_REPEAT && operand_i[14:0] != 15'h0000 |=> done_o
         && repeat_active_o && repeat_count_o == $past(operand_i[14:0])
         && repeat_mode_o == $past(sel[1:0]);
   endproperty
   a_rep_load: assert property (p_rep_load) else $error("repeat load wrong");
   property p_rep_pass;
      repeat_active_o && pass_i && !branch_met_i && repeat_count_o > 15'h0001
         |=> repeat_active_o && repeat_count_o == $past(repeat_count_o) - 15'h0001
         && $stable(pc_o);
   endproperty
   a_rep_pass: assert property (p_rep_pass) else $error("repeat pass wrong");
   property p_rep_end;
      repeat_active_o && pass_i && (branch_met_i || repeat_count_o == 15'h0001)
         |=> !repeat_active_o;
   endproperty
   a_rep_end: assert property (p_rep_end) else $error("repeat not ended");
   c_rj: cover property (iss && opcode_i == OP_MANUAL_RJ);
   c_buf_end: cover property ($fell(buf_in_active_o != 7'h00));
   c_rep_brk: cover property (repeat_active_o && pass_i && branch_met_i);
endmodule
bind rjb_exec rjb_exec_chk chk_i (.clock_i, .sys_rst_i, .start_i, .ready_o, .opcode_i,
   .branch_sel_i, .transfer_i, .operand_i, .chan_full_i, .pass_i, .branch_met_i, .done_o,
   .pc_o, .repeat_active_o, .repeat_mode_o, .repeat_count_o, .buf_in_active_o,
   .buf_out_active_o, .mem_req_o, .mem_ack_i, .mem_we_o, .mem_lo_en_o, .mem_hi_en_o,
   .mem_addr_o, .mem_wdata_o);

// File: dv/rjb_exec_tb.sv
/* Self-checking bench for rjb_exec with a storage model.
   Assumes one instruction in flight and a 125 MHz clock. */
`timescale 1ns/1ps
module rjb_exec_tb
   import rjb_pkg::*;
;
   logic clock_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0, pass_i = 1'b0, slow = 1'b0;
   logic branch_met_i = 1'b0, run_i = 1'b0, pc_load_i = 1'b0;
   logic [5:0] opcode_i = 6'h00;
   logic [2:0] branch_sel_i = 3'h0, transfer_i = 3'h0, chan_sel_o;
   logic [WORD_W-1:0] operand_i = '0, acc_i = '0, q_i = '0, chan_data_i = '0;
   logic [WORD_W-1:0] mem_rdata_i, mem_wdata_o, chan_data_o;
   logic [7:1] key_i = '0, chan_full_i = '0, xfer_req_i = '0, v;
   logic [7:1] buf_in_active_o, buf_out_active_o, xfer_ack_o;
   logic [HALF_W-1:0] pc_load_val_i = '0, pc_o, repeat_count_o, mem_addr_o, cur_pc;
   logic mem_ack_i, ready_o, done_o, halt_o, repeat_active_o, chan_wr_o, f;
   logic mem_req_o, mem_we_o, mem_lo_en_o, mem_hi_en_o;
   logic [1:0] repeat_mode_o;
   logic [15:0] exp_q [$];
   logic [15:0] e;
   int n_fail = 0, n_compared = 0, ch;
   rjb_exec uut (.clock_i, .sys_rst_i, .start_i, .opcode_i, .branch_sel_i, .transfer_i,
      .operand_i, .acc_i, .q_i, .key_i, .chan_full_i, .xfer_req_i, .chan_data_i, .pass_i,
      .branch_met_i, .run_i, .pc_load_i, .pc_load_val_i, .mem_ack_i, .mem_rdata_i, .ready_o,
      .done_o, .pc_o, .halt_o, .repeat_active_o, .repeat_mode_o, .repeat_count_o,
      .buf_in_active_o, .buf_out_active_o, .xfer_ack_o, .chan_sel_o, .chan_wr_o, .chan_data_o,
      .mem_req_o, .mem_we_o, .mem_lo_en_o, .mem_hi_en_o, .mem_addr_o, .mem_wdata_o);
   rjb_mem_model far (.clock_i, .sys_rst_i, .slow_i(slow), .req_i(mem_req_o),
      .we_i(mem_we_o), .lo_i(mem_lo_en_o), .hi_i(mem_hi_en_o), .addr_i(mem_addr_o),
      .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   always #4 clock_i = ~clock_i;
   task automatic chk(input string nm, input logic [29:0] x, input logic [29:0] g);
      n_compared++;
      if (g !== x) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, x, g);
      end
   endtask
   always @(negedge clock_i) begin
      if (done_o === 1'b1) begin
         e = exp_q.pop_front();
         chk("pc_o", 30'(e[14:0]), 30'(pc_o));
         chk("halt_o", 30'(e[15]), 30'(halt_o));
      end
   end
   task automatic step(input int c);
      repeat (c) @(posedge clock_i);
   endtask
   task automatic issue(input logic [5:0] op, input logic [2:0] j, input logic [2:0] k,
         input logic [29:0] y, input logic [14:0] ep, input logic eh);
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 50) begin
         @(negedge clock_i);
         n++;
      end
      exp_q.push_back({eh, ep});
      step(1);
      start_i <= 1'b1;
      opcode_i <= op;
      branch_sel_i <= j;
      transfer_i <= k;
      operand_i <= y;
      step(1);
      start_i <= 1'b0;
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (done_o !== 1'b1 && n < 50);
      chk("done_o", 30'h1, 30'(n < 50));
      cur_pc = ep;
   endtask
   task automatic rj(input logic [5:0] op, input int j, input logic tk, input logic h);
      logic [14:0] y, p;
      logic [29:0] old;
      y = 15'(8 + $urandom_range(23));
      p = 15'($urandom);
      old = 30'($urandom);
      far.mem_q[y[4:0]] = old;
      step(1);
      pc_load_i <= 1'b1;
      pc_load_val_i <= p;
      step(1);
      pc_load_i <= 1'b0;
      issue(op, 3'(j), 3'h0, {15'($urandom), y}, tk ? y + 15'h0001 : p, h && tk);
      chk("saved", tk ? {old[29:15], p} : old, far.mem_q[y[4:0]]);
      step(1);
      run_i <= 1'b1;
      step(1);
      run_i <= 1'b0;
   endtask
   task automatic pass(input logic m);
      step(1);
      pass_i <= 1'b1;
      branch_met_i <= m;
      step(1);
      pass_i <= 1'b0;
      @(negedge clock_i);
   endtask
   task automatic xfer(input logic [14:0] a, input logic din);
      logic [29:0] d, seen;
      int n;
      d = 30'($urandom);
      seen = ~far.mem_q[a[4:0]];
      n = 0;
      step(1);
      chan_data_i <= d;
      xfer_req_i[ch] <= 1'b1;
      step(2);
      xfer_req_i[ch] <= 1'b0;
      while (xfer_ack_o[ch] !== 1'b1 && n < 60) begin
         @(negedge clock_i);
         if (chan_wr_o === 1'b1) seen = chan_data_o;
         n++;
      end
      chk("xfer_ack", 30'h1, 30'(n < 60));
      chk("chan_sel", 30'(ch), 30'(chan_sel_o));
      chk("word", din ? d : far.mem_q[a[4:0]], din ? far.mem_q[a[4:0]] : seen);
      chk("next", 30'(a + 15'h0001), 30'(far.mem_q[ch][14:0]));
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      step(20000);
      n_fail++;
      $display("[ERR] run exp finish got timeout");
      end_of_test();
   end
   initial begin
      void'($urandom(46));
      step(6);
      sys_rst_i <= 1'b0;
      @(negedge clock_i);
      chk("reset", 30'h1, {pc_o, mem_req_o, 13'h0000, ready_o});
      for (int j = 0; j < 8; j++) begin
         step(1);
         key_i <= 7'($urandom);
         step(4);
         rj(OP_MANUAL_RJ, j, j == 0 || j > 3 || key_i[j], j == 4 || (j > 4 && key_i[j]));
      end
      $display("manual return test done");
      for (int j = 1; j < 8; j++) begin
         f = 1'($urandom);
         v = 7'($urandom);
         v[j] = f;
         chan_full_i <= v;
         rj(OP_INPUT_RJ, j, f, 1'b0);
         rj(OP_OUTPUT_RJ, j, !f, 1'b0);
      end
      $display("channel return test done");
      for (int j = 0; j < 8; j++) begin
         v = 7'($urandom);
         step(1);
         acc_i <= v[1] ? {30{v[2]}} : {v[2], 28'($urandom), !v[2]};
         q_i <= {v[3], 29'($urandom)};
         rj(OP_ARITH_RJ, j, 1'({v[2], !v[2], !v[1], v[1], v[3], !v[3], 2'h2} >> j), 1'b0);
      end
      $display("arithmetic return test done");
      for (int j = 0; j < 8; j++) begin
         issue(OP_REPEAT, 3'(j), 3'h0, {15'($urandom), 15'h0002}, cur_pc, 1'b0);
         chk("mode", 30'({2'(j % 4), 15'h0002}), 30'({repeat_mode_o, repeat_count_o}));
         pass(j[0]);
         chk("rep_on", 30'(!j[0]), 30'(repeat_active_o));
         if (!j[0]) begin
            pass(1'b0);
            chk("rep_end", 30'h0, 30'({repeat_count_o, repeat_active_o}));
         end
      end
      $display("repeat test done");
      issue(OP_REPEAT, 3'h7, 3'h0, 30'h0, cur_pc, 1'b0);
      for (int i = 0; i < 3; i++) begin
         chk("index", 30'(i), 30'({repeat_active_o, repeat_count_o}));
         issue(OP_INDEX_SKIP, 3'h7, 3'h0, 30'h2, cur_pc + 15'(i == 2), 1'b0);
      end
      issue(OP_INDEX_JUMP, 3'h7, 3'h0, {15'h7FFF, 15'h0123}, cur_pc, 1'b0);
      chk("index", 30'h0, 30'(repeat_count_o));
      issue(OP_INDEX_SKIP, 3'h7, 3'h3, 30'h5, cur_pc, 1'b0);
      issue(OP_INDEX_JUMP, 3'h7, 3'h0, {15'h5555, 15'h0040}, 15'h0040, 1'b0);
      chk("index", 30'h0, 30'(repeat_count_o));
      $display("index test done");
      ch = 1 + $urandom_range(6);
      issue(OP_INIT_IN_BUF, 3'(ch), K_FULL_WORD, {15'h0016, 15'h0014}, cur_pc, 1'b0);
      chk("ctl", {15'h0016, 15'h0014}, far.mem_q[ch]);
      slow <= 1'b1;
      xfer(15'h0014, 1'b1);
      chk("in_on", 30'h1, 30'(buf_in_active_o[ch]));
      xfer(15'h0015, 1'b1);
      chk("in_end", 30'h0, 30'(buf_in_active_o[ch]));
      far.mem_q[18] = 30'($urandom);
      issue(OP_INIT_OUT_BUF, 3'(ch), 3'h0, {15'h7FFF, 15'h0012}, cur_pc, 1'b0);
      chk("ctl", {15'h0016, 15'h0012}, far.mem_q[ch]);
      xfer(15'h0012, 1'b0);
      issue(OP_INIT_IN_BUF, 3'(ch), 3'h5, 30'hA, cur_pc, 1'b0);
      chk("modes", 30'h1, 30'({buf_out_active_o[ch], buf_in_active_o[ch]}));
      $display("buffer test done");
      end_of_test();
   end
endmodule
